/* File: pkg/cbm_pkg.sv */
// Shared constants and frame carriers for the six programmable message buffers
package cbm_pkg;
	localparam int          NUM_BUFS     = 6;             // Programmable buffers
	localparam int          NUM_FIELDS   = 13;            // Byte fields per buffer
	localparam logic [3:0]  FLD_SIDH     = 4'h0;          // Identifier high byte
	localparam logic [3:0]  FLD_SIDL     = 4'h1;          // Identifier low byte
	localparam logic [3:0]  FLD_EIDH     = 4'h2;          // Extended high byte
	localparam logic [3:0]  FLD_EIDL     = 4'h3;          // Extended low byte
	localparam logic [3:0]  FLD_DLC      = 4'h4;          // Length code register
	localparam logic [3:0]  FLD_DATA0    = 4'h5;          // First payload byte
	localparam logic [3:0]  FLD_CTRL     = 4'hD;          // Full/request/busy word
	localparam logic [8:0]  BUF_STRIDE   = 9'h040;        // Bytes per buffer window
	localparam logic [8:0]  OFS_BSEL     = 9'h180;        // Direction select
	localparam logic [8:0]  OFS_MODE     = 9'h184;        // Operating mode
	localparam logic [7:0]  BSEL_RESET   = 8'h00;         // All buffers receive
	localparam logic [1:0]  MODE_RESET   = 2'h0;          // Legacy mode after reset
	localparam logic [1:0]  MODE_LEGACY  = 2'h0;          // Buffers unusable
	localparam logic [7:0]  SIDL_TX_MASK = 8'hEB;         // Writable bits, ident low
	localparam logic [7:0]  DLC_TX_MASK  = 8'h4F;         // Writable bits, length code
	localparam int          SIDL_SRR     = 4;             // Substitute remote bit
	localparam int          SIDL_EXT     = 3;             // Extended frame flag
	localparam int          DLC_RTR      = 6;             // Remote request bit
	localparam logic [3:0]  DLC_MAX      = 4'h8;          // Largest legal length
	localparam int          CTRL_FULL    = 0;             // Receive full bit
	localparam int          CTRL_REQ     = 1;             // Transmit request bit
	localparam int          CTRL_BUSY    = 2;             // Transmission in progress
	localparam logic [1:0]  RESP_OKAY    = 2'h0;          // Bus answer, good
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;          // Bus answer, unmapped

	// Frame delivered by the protocol engine
	typedef struct packed {
		logic [2:0]  buf_idx;                         // Target buffer
		logic [28:0] ident;                           // Standard id in bits 10:0
		logic        ext;                             // Extended identifier frame
		logic        rtr;                             // Remote request frame
		logic [3:0]  dlc;                             // Data length code
		logic [63:0] data;                            // Byte 0 in bits 7:0
	} cbm_rx_frame_t;

	// Frame handed to the protocol engine
	typedef struct packed {
		logic [28:0] ident;                           // Standard id in bits 10:0
		logic        ext;                             // Extended identifier frame
		logic        rtr;                             // Remote request frame
		logic [3:0]  dlc;                             // Data length code
		logic [63:0] data;                            // Byte 0 in bits 7:0
	} cbm_tx_frame_t;

	// Transmit hand-off states
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_OFFER = 3'b010,
		TX_BUSY  = 3'b100
	} cbm_tx_state_t;
endpackage : cbm_pkg

/* File: verilog/cbm_buffers.sv */
// Six programmable message buffers with AXI4-Lite access and engine ports
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module cbm_buffers #(
	parameter int NBUF = cbm_pkg::NUM_BUFS
) (
	input  wire logic                  MCLK_IN,
	input  wire logic                  RST_IN,
	input  wire logic                  S_AXI_AWVALID_IN,
	output logic                       S_AXI_AWREADY_OUT,
	input  wire logic [8:0]            S_AXI_AWADDR_IN,
	input  wire logic                  S_AXI_WVALID_IN,
	output logic                       S_AXI_WREADY_OUT,
	input  wire logic [31:0]           S_AXI_WDATA_IN,
	input  wire logic [3:0]            S_AXI_WSTRB_IN,
	output logic                       S_AXI_BVALID_OUT,
	input  wire logic                  S_AXI_BREADY_IN,
	output logic [1:0]                 S_AXI_BRESP_OUT,
	input  wire logic                  S_AXI_ARVALID_IN,
	output logic                       S_AXI_ARREADY_OUT,
	input  wire logic [8:0]            S_AXI_ARADDR_IN,
	output logic                       S_AXI_RVALID_OUT,
	input  wire logic                  S_AXI_RREADY_IN,
	output logic [31:0]                S_AXI_RDATA_OUT,
	output logic [1:0]                 S_AXI_RRESP_OUT,
	input  wire logic                  RX_VALID_IN,
	output logic                       RX_READY_OUT,
	input  wire cbm_pkg::cbm_rx_frame_t RX_FRAME_IN,
	output logic                       TX_VALID_OUT,
	input  wire logic                  TX_READY_IN,
	output cbm_pkg::cbm_tx_frame_t     TX_FRAME_OUT,
	output logic [2:0]                 TX_BUF_OUT,
	input  wire logic                  TX_DONE_IN
);
	// Bus holding registers
	logic                    aw_held_r;          // Write address taken
	logic                    w_held_r;           // Write data taken
	logic                    awready_r;          // Write address ready, flop copy
	logic                    wready_r;           // Write data ready, flop copy
	logic [8:0]              waddr_r;            // Held write address
	logic [31:0]             wdata_r;            // Held write data
	logic [3:0]              wstrb_r;            // Held byte enables
	logic                    bvalid_r;           // Write answer pending
	logic                    arready_r;          // Read address ready
	logic                    rvalid_r;           // Read answer pending
	logic [31:0]             rdata_r;            // Read answer data
	logic [1:0]              rresp_r;            // Read answer status
	logic [1:0]              bresp_r;            // Write answer status
	// Configuration
	logic [7:0]              bsel_r;             // Direction select
	logic [1:0]              mode_r;             // Operating mode
	logic                    mode_ok;            // Enhanced mode active
	// Per-buffer state
	logic [NBUF-1:0][103:0]  img_w;              // Field bytes of each buffer
	logic [NBUF-1:0]         full_r;             // Receive full flags
	logic [NBUF-1:0]         req_r;              // Transmit request flags
	logic [NBUF-1:0]         lock_w;             // Fields frozen by transmit
	logic [NBUF-1:0]         dir_w;              // One means transmit
	// Two-entry receive buffer
	cbm_pkg::cbm_rx_frame_t  fifo_r [0:1];       // Stored frames
	logic                    wp_r;               // Write slot
	logic                    rp_r;               // Read slot
	logic [1:0]              cnt_r;              // Frames held
	logic                    rx_rdy_r;           // Ready toward engine
	cbm_pkg::cbm_rx_frame_t  rx_head;            // Oldest frame
	logic                    rx_push;            // Engine hands a frame
	logic                    rx_do;              // Oldest frame consumed
	logic                    rx_take;            // Consumed frame is stored
	logic [103:0]            rx_img;             // Stored form of the frame
	// Transmit hand-off
	cbm_pkg::cbm_tx_state_t  tx_st_r;            // Hand-off state
	logic [2:0]              tx_cur_r;           // Buffer being sent
	logic                    tx_valid_r;         // Offer to engine
	cbm_pkg::cbm_tx_frame_t  tx_frame_r;         // Frame offered
	logic                    tx_pick_ok;         // Some buffer requests
	logic [2:0]              tx_pick;            // Lowest requesting buffer
	// Decode
	logic                    wr_do;              // Write performed now
	logic [2:0]              wr_buf;             // Addressed buffer
	logic [3:0]              wr_fld;             // Addressed field
	logic [2:0]              rd_buf;             // Read buffer
	logic [3:0]              rd_fld;             // Read field
	logic [2:0]              last_idx_r;         // Buffer last loaded
	logic [103:0]            last_img;           // Its field bytes

	// Only codes 1 and 2 open the buffers; code 3 is left closed like legacy
	assign mode_ok = (mode_r != cbm_pkg::MODE_LEGACY) && (mode_r != 2'h3);
	assign dir_w   = NBUF'(bsel_r[7:2]);
	assign wr_do   = aw_held_r && w_held_r && !bvalid_r;
	assign wr_buf  = waddr_r[8:6];
	assign wr_fld  = waddr_r[5:2];
	assign rd_buf  = S_AXI_ARADDR_IN[8:6];
	assign rd_fld  = S_AXI_ARADDR_IN[5:2];

	// Write address and data taken in either order
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			waddr_r   <= 9'h000;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (S_AXI_AWVALID_IN && !aw_held_r) begin
				aw_held_r <= 1'b1;
				awready_r <= 1'b0;
				waddr_r   <= S_AXI_AWADDR_IN;
			end else if (wr_do) begin
				aw_held_r <= 1'b0;
				awready_r <= 1'b1;
			end
			if (S_AXI_WVALID_IN && !w_held_r) begin
				w_held_r <= 1'b1;
				wready_r <= 1'b0;
				wdata_r  <= S_AXI_WDATA_IN;
				wstrb_r  <= S_AXI_WSTRB_IN;
			end else if (wr_do) begin
				w_held_r <= 1'b0;
				wready_r <= 1'b1;
			end
		end
	end

	// Write answer, error for unmapped addresses
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			bvalid_r <= 1'b0;
			bresp_r  <= cbm_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			bresp_r  <= ((wr_buf < 3'(NBUF) && wr_fld <= cbm_pkg::FLD_CTRL)
				|| waddr_r == cbm_pkg::OFS_BSEL || waddr_r == cbm_pkg::OFS_MODE)
				? cbm_pkg::RESP_OKAY : cbm_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY_IN) begin
			bvalid_r <= 1'b0;
		end
	end

	// Direction and mode registers
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			bsel_r <= cbm_pkg::BSEL_RESET;
			mode_r <= cbm_pkg::MODE_RESET;
		end else if (wr_do && wstrb_r[0]) begin
			if (waddr_r == cbm_pkg::OFS_BSEL)
				bsel_r <= {wdata_r[7:2], 2'b00};
			if (waddr_r == cbm_pkg::OFS_MODE)
				mode_r <= wdata_r[1:0];
		end
	end

	// Read channel, answer one cycle after the address
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= cbm_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= cbm_pkg::RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
			if (S_AXI_ARADDR_IN == cbm_pkg::OFS_BSEL) begin
				rdata_r[7:0] <= bsel_r;
			end else if (S_AXI_ARADDR_IN == cbm_pkg::OFS_MODE) begin
				rdata_r[1:0] <= mode_r;
			end else if (rd_buf >= 3'(NBUF) || rd_fld > cbm_pkg::FLD_CTRL) begin
				rresp_r <= cbm_pkg::RESP_SLVERR;
			end else if (!mode_ok) begin
				rdata_r <= 32'h0000_0000;
			end else if (rd_fld == cbm_pkg::FLD_CTRL) begin
				rdata_r[cbm_pkg::CTRL_FULL] <= full_r[rd_buf];
				rdata_r[cbm_pkg::CTRL_REQ]  <= req_r[rd_buf];
				rdata_r[cbm_pkg::CTRL_BUSY] <= lock_w[rd_buf];
			end else begin
				rdata_r[7:0] <= img_w[rd_buf][rd_fld*8 +: 8];
			end
		end else if (rvalid_r && S_AXI_RREADY_IN) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Receive buffer; drain stalls while software writes
	assign rx_push = RX_VALID_IN && rx_rdy_r;
	assign rx_head = fifo_r[rp_r];
	assign rx_do   = (cnt_r != 2'd0) && !wr_do;
	assign rx_take = rx_do && mode_ok && !dir_w[rx_head.buf_idx]
		&& !full_r[rx_head.buf_idx] && rx_head.buf_idx < 3'(NBUF);

	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			wp_r     <= 1'b0;
			rp_r     <= 1'b0;
			cnt_r    <= 2'd0;
			rx_rdy_r <= 1'b1;
		end else begin
			if (rx_push) begin
				fifo_r[wp_r] <= RX_FRAME_IN;
				wp_r         <= ~wp_r;
			end
			if (rx_do)
				rp_r <= ~rp_r;
			cnt_r    <= cnt_r + 2'(rx_push) - 2'(rx_do);
			rx_rdy_r <= (cnt_r + 2'(rx_push) - 2'(rx_do)) < 2'd2;
		end
	end

	// Stored image of an accepted frame
	always_comb begin
		rx_img = '0;
		rx_img[cbm_pkg::FLD_DLC*8 +: 8] = {1'b0, rx_head.rtr, 2'b00, rx_head.dlc};
		rx_img[cbm_pkg::FLD_DATA0*8 +: 64] = rx_head.data;
		if (rx_head.ext) begin
			rx_img[cbm_pkg::FLD_SIDH*8 +: 8] = rx_head.ident[28:21];
			rx_img[cbm_pkg::FLD_SIDL*8 +: 8] =
				{rx_head.ident[20:18], 1'b1, 1'b1, 1'b0, rx_head.ident[17:16]};
			rx_img[cbm_pkg::FLD_EIDH*8 +: 8] = rx_head.ident[15:8];
			rx_img[cbm_pkg::FLD_EIDL*8 +: 8] = rx_head.ident[7:0];
		end else begin
			rx_img[cbm_pkg::FLD_SIDH*8 +: 8] = rx_head.ident[10:3];
			rx_img[cbm_pkg::FLD_SIDL*8 +: 8] =
				{rx_head.ident[2:0], rx_head.rtr, 1'b0, 3'b000};
		end
	end

	// Per-buffer fields and flags
	genvar g;
	generate
		for (g = 0; g < NBUF; g++) begin : gen_buf
			logic [12:0][7:0] fld_r;                  // Field bytes
			logic             hit;                    // Write addresses this buffer
			logic             load;                   // Frame lands here
			logic [7:0]       mask;                   // Writable bits of field
			assign hit    = wr_do && wr_buf == 3'(g);
			assign load   = rx_take && rx_head.buf_idx == 3'(g);
			assign img_w[g] = fld_r;
			assign lock_w[g] = req_r[g] || (!tx_st_r[0] && tx_cur_r == 3'(g));
			assign mask = (wr_fld == cbm_pkg::FLD_SIDL) ? cbm_pkg::SIDL_TX_MASK :
				(wr_fld == cbm_pkg::FLD_DLC) ? cbm_pkg::DLC_TX_MASK : 8'hFF;

			// Field bytes: engine loads receive, software fills transmit
			always_ff @(posedge MCLK_IN or posedge RST_IN) begin
				if (RST_IN) begin
					fld_r <= '0;
				end else if (load) begin
					fld_r <= rx_img;
				end else if (hit && wstrb_r[0] && wr_fld < cbm_pkg::FLD_CTRL && mode_ok
					&& dir_w[g] && !lock_w[g]) begin
					fld_r[wr_fld] <= wdata_r[7:0] & mask;
				end
			end

			// Full flag: load wins over a clearing write
			always_ff @(posedge MCLK_IN or posedge RST_IN) begin
				if (RST_IN) begin
					full_r[g] <= 1'b0;
				end else if (load) begin
					full_r[g] <= 1'b1;
				end else if (hit && wr_fld == cbm_pkg::FLD_CTRL && wstrb_r[0]
					&& !wdata_r[cbm_pkg::CTRL_FULL]) begin
					full_r[g] <= 1'b0;
				end
			end

			// Transmit request: set by software, ended by the engine
			always_ff @(posedge MCLK_IN or posedge RST_IN) begin
				if (RST_IN) begin
					req_r[g] <= 1'b0;
				end else if (tx_st_r == cbm_pkg::TX_BUSY && TX_DONE_IN
					&& tx_cur_r == 3'(g)) begin
					req_r[g] <= 1'b0;
				end else if (hit && wr_fld == cbm_pkg::FLD_CTRL && wstrb_r[0] && mode_ok
					&& dir_w[g] && wdata_r[cbm_pkg::CTRL_REQ]) begin
					req_r[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// Lowest numbered requesting buffer
	always_comb begin
		tx_pick_ok = 1'b0;
		tx_pick    = 3'd0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (req_r[i] && dir_w[i]) begin
				tx_pick_ok = 1'b1;
				tx_pick    = 3'(i);
			end
		end
	end

	// Hand-off of a frame to the engine
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tx_st_r    <= cbm_pkg::TX_IDLE;
			tx_cur_r   <= 3'd0;
			tx_valid_r <= 1'b0;
			tx_frame_r <= '0;
		end else begin
			unique case (tx_st_r)
				cbm_pkg::TX_IDLE: begin
					if (tx_pick_ok && mode_ok) begin
						tx_st_r    <= cbm_pkg::TX_OFFER;
						tx_cur_r   <= tx_pick;
						tx_valid_r <= 1'b1;
						tx_frame_r <= tx_build(img_w[tx_pick]);
					end
				end
				cbm_pkg::TX_OFFER: begin
					if (TX_READY_IN) begin
						tx_st_r    <= cbm_pkg::TX_BUSY;
						tx_valid_r <= 1'b0;
					end
				end
				cbm_pkg::TX_BUSY: begin
					if (TX_DONE_IN)
						tx_st_r <= cbm_pkg::TX_IDLE;
				end
				default: begin
					tx_st_r    <= cbm_pkg::TX_IDLE;
					tx_valid_r <= 1'b0;
				end
			endcase
		end
	end

	// Frame from transmit buffer bytes
	function automatic cbm_pkg::cbm_tx_frame_t tx_build(input logic [103:0] b);
		cbm_pkg::cbm_tx_frame_t f;
		logic [7:0]             sidl;
		logic [7:0]             dlc;
		sidl   = b[cbm_pkg::FLD_SIDL*8 +: 8];
		dlc    = b[cbm_pkg::FLD_DLC*8 +: 8];
		f.ext  = sidl[cbm_pkg::SIDL_EXT];
		f.rtr  = dlc[cbm_pkg::DLC_RTR];
		f.dlc  = (dlc[3:0] > cbm_pkg::DLC_MAX) ? cbm_pkg::DLC_MAX : dlc[3:0];
		f.data = b[cbm_pkg::FLD_DATA0*8 +: 64];
		if (f.ext)
			f.ident = {b[cbm_pkg::FLD_SIDH*8 +: 8], sidl[7:5], sidl[1:0],
				b[cbm_pkg::FLD_EIDH*8 +: 8], b[cbm_pkg::FLD_EIDL*8 +: 8]};
		else
			f.ident = {18'h0_0000, b[cbm_pkg::FLD_SIDH*8 +: 8], sidl[7:5]};
		return f;
	endfunction : tx_build

	// Output registers
	assign S_AXI_AWREADY_OUT = awready_r;
	assign S_AXI_WREADY_OUT  = wready_r;
	assign S_AXI_BVALID_OUT  = bvalid_r;
	assign S_AXI_BRESP_OUT   = bresp_r;
	assign S_AXI_ARREADY_OUT = arready_r;
	assign S_AXI_RVALID_OUT  = rvalid_r;
	assign S_AXI_RDATA_OUT   = rdata_r;
	assign S_AXI_RRESP_OUT   = rresp_r;
	assign RX_READY_OUT      = rx_rdy_r;
	assign TX_VALID_OUT      = tx_valid_r;
	assign TX_FRAME_OUT      = tx_frame_r;
	assign TX_BUF_OUT        = tx_cur_r;

	// Helper: buffer most recently loaded
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN)
			last_idx_r <= 3'd0;
		else if (rx_take)
			last_idx_r <= rx_head.buf_idx;
	end
	assign last_img = img_w[last_idx_r];

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);

	property p_srr_ext;
		rx_take && rx_head.ext |=> last_img[cbm_pkg::FLD_SIDL*8 + cbm_pkg::SIDL_SRR];
	endproperty
	a_srr_ext: assert property (p_srr_ext) else $error("srr not one on extended");

	property p_srr_std;
		rx_take && !rx_head.ext
			|=> last_img[cbm_pkg::FLD_SIDL*8 + cbm_pkg::SIDL_SRR] == $past(rx_head.rtr);
	endproperty
	a_srr_std: assert property (p_srr_std) else $error("srr not copy of remote");

	property p_ext_flag;
		rx_take |=> last_img[cbm_pkg::FLD_SIDL*8 + cbm_pkg::SIDL_EXT] == $past(rx_head.ext);
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("extended flag wrong");

	property p_low_id;
		rx_take && rx_head.ext
			|=> last_img[cbm_pkg::FLD_SIDL*8 + 5 +: 3] == $past(rx_head.ident[20:18]);
	endproperty
	a_low_id: assert property (p_low_id) else $error("id bits 20:18 misplaced");

	property p_rx_rtr;
		rx_take |=> last_img[cbm_pkg::FLD_DLC*8 + 4 +: 3] == {$past(rx_head.rtr), 2'b00};
	endproperty
	a_rx_rtr: assert property (p_rx_rtr) else $error("length bits 6:4 wrong");

	property p_full_set;
		rx_take |=> full_r[last_idx_r];
	endproperty
	a_full_set: assert property (p_full_set) else $error("full flag not set");

	property p_lock;
		wr_do && wr_buf < 3'(NBUF) && lock_w[wr_buf] && wr_fld < cbm_pkg::FLD_CTRL
			|=> img_w[wr_buf] == $past(img_w[wr_buf]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked buffer changed");

	property p_std_tx;
		TX_VALID_OUT && !TX_FRAME_OUT.ext |-> TX_FRAME_OUT.ident[28:11] == 18'h0_0000;
	endproperty
	a_std_tx: assert property (p_std_tx) else $error("standard id has high bits");

	property p_tx_len;
		TX_VALID_OUT |-> TX_FRAME_OUT.dlc <= cbm_pkg::DLC_MAX && req_r[TX_BUF_OUT];
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("bad transmit offer");

	property p_legacy;
		!mode_ok && tx_st_r == cbm_pkg::TX_IDLE |=> !TX_VALID_OUT && !$rose(|full_r);
	endproperty
	a_legacy: assert property (p_legacy) else $error("buffer used in legacy mode");
endmodule : cbm_buffers

/* File: testbench/cbm_engine_model.sv */
// Behavioural protocol engine facing the message buffers
`timescale 1ns/10ps
module cbm_engine_model (
	input  wire logic                   clk_in,
	input  wire logic                   tx_valid_in,
	input  wire cbm_pkg::cbm_tx_frame_t tx_frame_in,
	input  wire logic                   rx_ready_in,
	input  wire logic                   slow_in,
	output logic                        tx_ready_out,
	output logic                        tx_done_out,
	output logic                        rx_valid_out,
	output cbm_pkg::cbm_rx_frame_t      rx_frame_out,
	output cbm_pkg::cbm_tx_frame_t      sent_out,
	output int                          sent_cnt_out,
	output logic                        hung_out
);
	int wait_c;  // Busy countdown, negative while stalling
	// Idle values
	initial begin
		{tx_ready_out, tx_done_out, rx_valid_out, hung_out} = 4'h0;
		rx_frame_out = '0;
		sent_cnt_out = 0;
		wait_c = 0;
	end
	// Offer one frame, held until taken, then scrambled
	task automatic send(input cbm_pkg::cbm_rx_frame_t f);
		int n;
		n = 0;
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_frame_out <= f;
		do @(posedge clk_in); while (!rx_ready_in && n++ < 50);
		// Offer never taken: flag it for the closing report
		if (!rx_ready_in) hung_out <= 1'b1;
		rx_valid_out <= 1'b0;
		rx_frame_out <= ~f;
	endtask : send
	// Accept offers promptly or late, then report completion
	always @(posedge clk_in) begin
		tx_done_out <= 1'b0;
		if (tx_valid_in && tx_ready_out) begin
			sent_out <= tx_frame_in;
			sent_cnt_out <= sent_cnt_out + 1;
			tx_ready_out <= 1'b0;
			wait_c <= 5;
		end else if (wait_c > 1) begin
			wait_c <= wait_c - 1;
		end else if (wait_c == 1) begin
			tx_done_out <= 1'b1;
			wait_c <= 0;
		end else if (tx_valid_in) begin
			if (!slow_in || wait_c < -3) tx_ready_out <= 1'b1;
			else wait_c <= wait_c - 1;
		end
	end
endmodule : cbm_engine_model

/* File: testbench/cbm_buffers_tb.sv */
// Self-checking bench for the message buffers
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
$display("[FAIL] %0t got %h want %h", $time, a, e); end end
module cbm_buffers_tb;
	logic                   MCLK_IN, RST_IN, awv, wv, br, arv, rr, slow; // Drives
	logic [8:0]             awa, ara;                                  // Addresses
	logic [31:0]            wd, rd, rdat;                              // Bus words
	logic [1:0]             resp, bre, rre;                            // Answers
	logic                   awr, wr, bv, arr, rv, rxv, rxr, txv, txr, txd;
	logic [2:0]             txb;                                       // Sending buffer
	logic                   hung;                                      // Engine offer stuck
	cbm_pkg::cbm_rx_frame_t rxf, f;                                    // Receive frames
	cbm_pkg::cbm_tx_frame_t txf, sent, e;                              // Transmit frames
	logic [7:0]             b [13];                                    // Field bytes
	int                     err_count, cmp_count, sent_cnt, n, c, seed;
	cbm_buffers dut (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
		.S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bre),
		.S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rdat),
		.S_AXI_RRESP_OUT(rre), .RX_VALID_IN(rxv), .RX_READY_OUT(rxr), .RX_FRAME_IN(rxf),
		.TX_VALID_OUT(txv), .TX_READY_IN(txr), .TX_FRAME_OUT(txf), .TX_BUF_OUT(txb),
		.TX_DONE_IN(txd));
	cbm_engine_model eng (.clk_in(MCLK_IN), .tx_valid_in(txv), .tx_frame_in(txf),
		.rx_ready_in(rxr), .slow_in(slow), .tx_ready_out(txr), .tx_done_out(txd),
		.rx_valid_out(rxv), .rx_frame_out(rxf), .sent_out(sent), .sent_cnt_out(sent_cnt),
		.hung_out(hung));
	// Free-running clock
	initial begin
		MCLK_IN = 1'b0;
		forever #12.5 MCLK_IN = ~MCLK_IN;
	end
	// Byte address of a buffer field
	function automatic logic [8:0] fa(int bn, int k);
		return cbm_pkg::BUF_STRIDE * 9'(bn) + 9'(4 * k);
	endfunction : fa
	// Readable bits of a transmit field
	function automatic logic [7:0] msk(int k);
		return k == 1 ? cbm_pkg::SIDL_TX_MASK : (k == 4 ? cbm_pkg::DLC_TX_MASK : 8'hFF);
	endfunction : msk
	// Expected receive field contents
	function automatic logic [7:0] rx_exp(cbm_pkg::cbm_rx_frame_t g, int k);
		case (k)
			0: return g.ext ? g.ident[28:21] : g.ident[10:3];
			1: return g.ext ? {g.ident[20:18], 3'h6, g.ident[17:16]} : {g.ident[2:0], g.rtr, 4'h0};
			2: return g.ext ? g.ident[15:8] : 8'h00;
			3: return g.ext ? g.ident[7:0] : 8'h00;
			4: return {1'b0, g.rtr, 2'h0, g.dlc};
			default: return g.data[8 * (k - 5) +: 8];
		endcase
	endfunction : rx_exp
	// Cut a hung wait short
	task automatic expire;
		if (n >= 60) begin
			err_count++;
			$display("[FAIL] %0t no answer", $time);
			complete_run();
		end
	endtask : expire
	// Bus write of one byte
	task automatic axw(input logic [8:0] a, input logic [7:0] d);
		@(posedge MCLK_IN);
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		awa <= a;
		wd <= {24'h0000_00, d};
		n = 0;
		do begin
			@(posedge MCLK_IN);
			n++;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv && n < 60);
		resp = bre;
		br <= 1'b0;
		expire();
	endtask : axw
	// Bus read of one word
	task automatic axr(input logic [8:0] a);
		@(posedge MCLK_IN);
		arv <= 1'b1;
		rr <= 1'b1;
		ara <= a;
		n = 0;
		do begin
			@(posedge MCLK_IN);
			n++;
			if (arr) arv <= 1'b0;
		end while (!rv && n < 60);
		rd = rdat;
		resp = rre;
		rr <= 1'b0;
		expire();
	endtask : axr
	// Verdict
	task automatic complete_run;
		if (hung) begin
			err_count++;
			$display("[FAIL] %0t engine offer never taken", $time);
		end
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		seed = 39;
		{RST_IN, awv, wv, br, arv, rr, slow} = 7'h40;
		{awa, ara, wd} = 50'h0;
		{err_count, cmp_count} = 64'h0;
		repeat (16) @(posedge MCLK_IN);
		RST_IN <= 1'b0;
		f = '1;
		f.buf_idx = 3'h0;
		eng.send(f);
		axr(fa(0, 0));
		`CHK(rd, 32'h0000_0000)
		axr(cbm_pkg::OFS_BSEL);
		`CHK(rd, 32'h0000_0000)
		axw(cbm_pkg::OFS_MODE, 8'h01);
		axr(fa(0, 13));
		`CHK(rd[0], 1'b0)
		axw(cbm_pkg::OFS_BSEL, 8'hFF);
		axr(cbm_pkg::OFS_BSEL);
		`CHK(rd, 32'h0000_00FC)
		`CHK(resp, cbm_pkg::RESP_OKAY)
		axw(cbm_pkg::OFS_BSEL, 8'hE0);
		axw(9'h1FC, 8'h00);
		`CHK(resp, cbm_pkg::RESP_SLVERR)
		$display("mode and select test done");
		for (int i = 0; i <= 8; i++) begin
			f.ident = 29'($random(seed));
			f.data = {$random(seed), $random(seed)};
			{f.ext, f.rtr, f.buf_idx, f.dlc} = {i[0], i[1], 3'(i % 3), 4'(i)};
			eng.send(f);
			axw(fa(f.buf_idx, 0), 8'h5A);
			eng.send({f.buf_idx, ~f[98:0]});
			repeat (4) @(posedge MCLK_IN);
			for (int k = 0; k < 13; k++) begin
				if (k < 5 || k - 5 < i) begin
					axr(fa(f.buf_idx, k));
					`CHK(rd, {24'h0000_00, rx_exp(f, k)})
				end
			end
			axr(fa(f.buf_idx, 13));
			`CHK(rd[0], 1'b1)
			axw(fa(f.buf_idx, 13), 8'h00);
		end
		$display("receive test done");
		for (int t = 0; t < 6; t++) begin
			slow <= t[0];
			for (int k = 0; k < 13; k++) b[k] = 8'($random(seed));
			b[4] = {1'b0, b[4][6], 2'h0, 4'(t + 3)};
			for (int k = 0; k < 13; k++) begin
				axw(fa(3 + t % 3, k), b[k]);
				axr(fa(3 + t % 3, k));
				`CHK(rd[7:0], b[k] & msk(k))
			end
			c = sent_cnt;
			axw(fa(3 + t % 3, 13), 8'h02);
			axw(fa(3 + t % 3, 0), ~b[0]);
			e.ext = b[1][3];
			e.ident = e.ext ? {b[0], b[1][7:5], b[1][1:0], b[2], b[3]} : {18'h0, b[0], b[1][7:5]};
			{e.rtr, e.dlc} = {b[4][6], b[4][3:0]};
			for (int m = 0; m < 8; m++) e.data[8 * m +: 8] = b[5 + m];
			n = 0;
			while (sent_cnt == c && n < 60) begin
				@(posedge MCLK_IN);
				n++;
			end
			expire();
			`CHK(sent, e)
			`CHK(txb, 3'(3 + t % 3))
			repeat (8) @(posedge MCLK_IN);
		end
		$display("transmit test done");
		complete_run();
	end
endmodule : cbm_buffers_tb
